// ### src/spb_pkg.sv
// shared constants for the serial port buffer and baud divider block
package spb_pkg;

  // =========================================================
  // register byte offsets
  localparam logic [7:0] ADR_RX_DATA   = 8'h00;
  localparam logic [7:0] ADR_TX_DATA   = 8'h04;
  localparam logic [7:0] ADR_BAUD_LO   = 8'h08;
  localparam logic [7:0] ADR_BAUD_HI   = 8'h0C;
  localparam logic [7:0] ADR_RX_CTRL   = 8'h10;
  localparam logic [7:0] ADR_TX_CTRL   = 8'h14;
  localparam logic [7:0] ADR_BAUD_CTRL = 8'h18;

  // =========================================================
  // field positions
  localparam int RX_NINTH_BIT      = 0;
  localparam int RX_FULL_BIT       = 1;
  localparam int TX_NINTH_BIT      = 0;
  localparam int TX_FREE_BIT       = 1;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int TX_SYNC_BIT       = 4;
  localparam int BAUD_WIDE_BIT     = 3;

  // =========================================================
  // writable masks and reset values
  localparam logic [7:0] RX_CTRL_WMASK   = 8'hFC;
  localparam logic [7:0] TX_CTRL_WMASK   = 8'hFD;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h1B;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // =========================================================
  // prescale factors
  localparam logic [6:0] PRE_SLOW = 7'h40;
  localparam logic [6:0] PRE_MID  = 7'h10;
  localparam logic [6:0] PRE_FAST = 7'h04;

  // =========================================================
  // register selects
  typedef enum logic [2:0] {
    SPB_SEL_NONE,
    SPB_SEL_RX_DATA,
    SPB_SEL_TX_DATA,
    SPB_SEL_BAUD_LO,
    SPB_SEL_BAUD_HI,
    SPB_SEL_RX_CTRL,
    SPB_SEL_TX_CTRL,
    SPB_SEL_BAUD_CTRL
  } spb_sel_e;

endpackage

// ### src/spb_fifo.sv
// receive character fifo with valid and ready on both sides
`timescale 1ns/1ps
module spb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count      <= next_count;
      in_ready_o <= (next_count != (AW + 1)'(DEPTH));
    end
  end
endmodule

// ### src/spb_core.sv
// serial port data buffers and baud divider behind a wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module spb_core
  import spb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_char_valid_i,
  input  wire logic [8:0]  rx_char_i,
  output logic             rx_char_ready_o,
  output logic             tx_char_valid_o,
  output logic      [8:0]  tx_char_o,
  input  wire logic        tx_char_ready_i,
  output logic             baud_tick_o
);

  // =========================================================
  // address decode
  function automatic spb_sel_e decode(input logic [7:0] adr);
    case (adr)
      ADR_RX_DATA:   decode = SPB_SEL_RX_DATA;
      ADR_TX_DATA:   decode = SPB_SEL_TX_DATA;
      ADR_BAUD_LO:   decode = SPB_SEL_BAUD_LO;
      ADR_BAUD_HI:   decode = SPB_SEL_BAUD_HI;
      ADR_RX_CTRL:   decode = SPB_SEL_RX_CTRL;
      ADR_TX_CTRL:   decode = SPB_SEL_TX_CTRL;
      ADR_BAUD_CTRL: decode = SPB_SEL_BAUD_CTRL;
      default:       decode = SPB_SEL_NONE;
    endcase
  endfunction

  spb_sel_e    sel;
  logic        acc;
  logic        wr_go;
  logic        rx_pop;
  logic        restart;
  logic [7:0]  baud_divisor_low;
  logic [7:0]  baud_divisor_high;
  logic [7:0]  rx_ctrl;
  logic [7:0]  tx_ctrl;
  logic [7:2]  rx_keep;
  logic [7:2]  tx_keep;
  logic        tx_ninth_bit;
  logic [7:0]  baud_control;
  logic        rx_full;
  logic [8:0]  rx_word;
  logic        fifo_valid;
  logic [8:0]  fifo_data;
  logic        fifo_ready;
  logic [7:0]  rd_byte;
  logic        wide_divider_select;
  logic        high_speed_select;
  logic        sync_mode;
  logic [6:0]  pre_div;
  logic [15:0] div_limit;
  logic [6:0]  pre_cnt;
  logic [15:0] div_cnt;
  logic        pre_last;
  logic        div_last;

  assign sel     = decode(wb_adr_i);
  assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go   = acc & wb_we_i & wb_sel_i[0];
  assign rx_pop  = acc & ~wb_we_i & (sel == SPB_SEL_RX_DATA);
  assign restart = wr_go & ((sel == SPB_SEL_BAUD_LO) |
                            (sel == SPB_SEL_BAUD_HI));

  assign wide_divider_select = baud_control[BAUD_WIDE_BIT];
  assign high_speed_select   = tx_ctrl[TX_HIGH_SPEED_BIT];
  assign sync_mode           = tx_ctrl[TX_SYNC_BIT];

  // =========================================================
  // wishbone answer
  always_comb begin
    case (sel)
      SPB_SEL_RX_DATA:   rd_byte = rx_word[7:0];
      SPB_SEL_TX_DATA:   rd_byte = tx_char_o[7:0];
      SPB_SEL_BAUD_LO:   rd_byte = baud_divisor_low;
      SPB_SEL_BAUD_HI:   rd_byte = baud_divisor_high;
      SPB_SEL_RX_CTRL:   rd_byte = rx_ctrl;
      SPB_SEL_TX_CTRL:   rd_byte = tx_ctrl;
      SPB_SEL_BAUD_CTRL: rd_byte = baud_control;
      default:           rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // =========================================================
  // control registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      baud_divisor_low  <= RST_BYTE;
      baud_divisor_high <= RST_BYTE;
      baud_control      <= RST_BYTE;
    end else if (wr_go) begin
      if (sel == SPB_SEL_BAUD_LO) begin
        baud_divisor_low <= wb_dat_i[7:0];
      end
      if (sel == SPB_SEL_BAUD_HI) begin
        baud_divisor_high <= wb_dat_i[7:0];
      end
      if (sel == SPB_SEL_BAUD_CTRL) begin
        baud_control <= wb_dat_i[7:0] & BAUD_CTRL_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_keep <= RST_BYTE[7:2];
    end else if (wr_go && sel == SPB_SEL_RX_CTRL) begin
      rx_keep <= wb_dat_i[7:2] & RX_CTRL_WMASK[7:2];
    end
  end
  assign rx_ctrl = {rx_keep, rx_full, rx_word[8]};

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_keep      <= RST_BYTE[7:2];
      tx_ninth_bit <= RST_BYTE[0];
    end else if (wr_go && sel == SPB_SEL_TX_CTRL) begin
      tx_keep      <= wb_dat_i[7:2] & TX_CTRL_WMASK[7:2];
      tx_ninth_bit <= wb_dat_i[TX_NINTH_BIT];
    end
  end
  assign tx_ctrl = {tx_keep, ~tx_char_valid_o, tx_ninth_bit};

  // =========================================================
  // transmit holding buffer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_char_valid_o <= 1'b0;
      tx_char_o       <= 9'h000;
    end else begin
      if (tx_char_valid_o && tx_char_ready_i) begin
        tx_char_valid_o <= 1'b0;
      end
      if (wr_go && sel == SPB_SEL_TX_DATA &&
          (!tx_char_valid_o || tx_char_ready_i)) begin
        tx_char_valid_o <= 1'b1;
        tx_char_o       <= {tx_ctrl[TX_NINTH_BIT], wb_dat_i[7:0]};
      end
    end
  end

  // =========================================================
  // receive path
  spb_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (rx_char_valid_i),
    .in_data_i   (rx_char_i),
    .in_ready_o  (rx_char_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_ready)
  );

  assign fifo_ready = ~rx_full | rx_pop;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_full <= 1'b0;
      rx_word <= 9'h000;
    end else if (fifo_valid && fifo_ready) begin
      rx_full <= 1'b1;
      rx_word <= fifo_data;
    end else if (rx_pop) begin
      rx_full <= 1'b0;
    end
  end

  // =========================================================
  // baud rate generator
  always_comb begin
    if (sync_mode) begin
      pre_div = PRE_FAST;
    end else if (wide_divider_select) begin
      pre_div = high_speed_select ? PRE_FAST : PRE_MID;
    end else begin
      pre_div = high_speed_select ? PRE_MID : PRE_SLOW;
    end
  end

  assign div_limit = wide_divider_select ?
                     {baud_divisor_high, baud_divisor_low} :
                     {8'h00, baud_divisor_low};
  assign pre_last  = (pre_cnt >= pre_div - 7'h01);
  assign div_last  = (div_cnt >= div_limit);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || restart) begin
      pre_cnt <= 7'h00;
      div_cnt <= 16'h0000;
    end else if (pre_last) begin
      pre_cnt <= 7'h00;
      div_cnt <= div_last ? 16'h0000 : div_cnt + 16'h0001;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      baud_tick_o <= 1'b0;
    end else begin
      baud_tick_o <= pre_last & div_last & ~restart;
    end
  end

  // =========================================================
  // checks
  logic [22:0] period;
  logic [22:0] period_q;
  logic [22:0] gap_cnt;
  logic        gap_seen;

  assign period = {16'h0000, pre_div} * ({7'h00, div_limit} + 23'h000001);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      period_q <= 23'h000000;
      gap_cnt  <= 23'h000000;
      gap_seen <= 1'b0;
    end else begin
      period_q <= period;
      gap_cnt  <= baud_tick_o ? 23'h000001 : gap_cnt + 23'h000001;
      if (restart || period != period_q) begin
        gap_seen <= 1'b0;
      end else if (baud_tick_o) begin
        gap_seen <= 1'b1;
      end
    end
  end

  property p_rx_load;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (fifo_valid && fifo_ready) |=> (rx_full && rx_word == $past(fifo_data));
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("receive buffer did not take fifo word");

  property p_rx_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rx_full && !rx_pop) |=> (rx_full && $stable(rx_word));
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("held receive character changed before read");

  property p_tx_load;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_go && sel == SPB_SEL_TX_DATA && !tx_char_valid_o) |=>
      (tx_char_valid_o &&
       tx_char_o == {$past(tx_ctrl[TX_NINTH_BIT]), $past(wb_dat_i[7:0])});
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit buffer did not load written character");

  property p_tx_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (tx_char_valid_o && !tx_char_ready_i) |=>
      (tx_char_valid_o && $stable(tx_char_o));
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("pending transmit character lost or overwritten");

  property p_lo_restart;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_go && sel == SPB_SEL_BAUD_LO) |=>
      (pre_cnt == 7'h00 && div_cnt == 16'h0000 && !baud_tick_o);
  endproperty
  a_lo_restart: assert property (p_lo_restart)
    else $error("low divider write did not restart counter");

  property p_hi_restart;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_go && sel == SPB_SEL_BAUD_HI) |=>
      (pre_cnt == 7'h00 && div_cnt == 16'h0000 &&
       baud_divisor_high == $past(wb_dat_i[7:0]));
  endproperty
  a_hi_restart: assert property (p_hi_restart)
    else $error("high divider write did not restart counter");

  property p_narrow;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !wide_divider_select |-> (div_limit == {8'h00, baud_divisor_low});
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("high divider byte used in narrow mode");

  property p_slow_prescale;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sync_mode && !high_speed_select && !wide_divider_select) |->
      (pre_div == PRE_SLOW);
  endproperty
  a_slow_prescale: assert property (p_slow_prescale)
    else $error("slow async narrow prescale wrong");

  property p_fast_prescale;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (sync_mode || (high_speed_select && wide_divider_select)) |->
      (pre_div == PRE_FAST);
  endproperty
  a_fast_prescale: assert property (p_fast_prescale)
    else $error("fast or clocked prescale wrong");

  property p_wide_select;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wide_divider_select |->
      (div_limit == {baud_divisor_high, baud_divisor_low});
  endproperty
  a_wide_select: assert property (p_wide_select)
    else $error("wide divider not formed from both bytes");

  property p_sync_ignores_speed;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (sync_mode && $stable(sync_mode) && $changed(high_speed_select)) |->
      $stable(pre_div);
  endproperty
  a_sync_ignores_speed: assert property (p_sync_ignores_speed)
    else $error("speed select affected clocked mode");

  property p_tick_period;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (baud_tick_o && gap_seen && !restart && period == period_q) |->
      (gap_cnt == period);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("baud tick spacing differs from mode period");

  c_tick: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    baud_tick_o && gap_seen);
  c_tx_taken: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_char_valid_o && tx_char_ready_i);
  c_rx_pop_refill: cover property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rx_pop && fifo_valid);
  c_fifo_full: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !rx_char_ready_o && rx_char_valid_i);

endmodule

// ### sim/spb_partner.sv
// far side model: receive shifter source and transmit shifter sink
`timescale 1ns/1ps
module spb_partner (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       stall_i,
  input  wire logic       tx_char_valid_i,
  input  wire logic [8:0] tx_char_i,
  output logic            tx_char_ready_o,
  input  wire logic       rx_char_ready_i,
  output logic            rx_char_valid_o,
  output logic      [8:0] rx_char_o
);
  logic [8:0] tx_got[$];

  initial begin
    rx_char_valid_o = 1'b0;
    rx_char_o       = 9'h000;
  end

  // ==========================================================
  // transmit sink, holds off while stalled
  always @(posedge core_clk_i) begin
    tx_char_ready_o <= !sys_rst_i && !stall_i;
    if (tx_char_valid_i && tx_char_ready_o) begin
      tx_got.push_back(tx_char_i);
    end
  end

  // ==========================================================
  // receive source, holds until taken, then scrambles the line
  task automatic send(input logic [8:0] c);
    @(posedge core_clk_i);
    rx_char_valid_o <= 1'b1;
    rx_char_o       <= c;
    do begin
      @(posedge core_clk_i);
    end while (rx_char_ready_i !== 1'b1);
    rx_char_valid_o <= 1'b0;
    rx_char_o       <= ~c;
  endtask
endmodule

// ### sim/spb_core_test.sv
// self-checking bench for the serial port buffers and baud divider
`timescale 1ns/1ps
module spb_core_test;
  import spb_pkg::*;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat_w = 32'h00000000;
  logic        stall = 1'b0;
  logic [31:0] dat_r;
  logic        ack;
  logic        rxv;
  logic [8:0]  rxc;
  logic        rxr;
  logic        txv;
  logic [8:0]  txc;
  logic        txr;
  logic        tick;
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          c1;
  int          c2;
  int          c3;
  int          gap_exp;
  int          p_tab[6]         = '{64, 16, 16, 4, 4, 4};
  logic [7:0]  tx_tab[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
  logic [7:0]  bc_tab[6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};

  spb_core #(.FIFO_DEPTH(8)) i_spb_core (
    .core_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .rx_char_valid_i(rxv),
    .rx_char_i(rxc), .rx_char_ready_o(rxr), .tx_char_valid_o(txv),
    .tx_char_o(txc), .tx_char_ready_i(txr), .baud_tick_o(tick));

  spb_partner i_spb_partner (
    .core_clk_i(clk), .sys_rst_i(rst), .stall_i(stall),
    .tx_char_valid_i(txv), .tx_char_i(txc), .tx_char_ready_o(txr),
    .rx_char_ready_i(rxr), .rx_char_valid_o(rxv), .rx_char_o(rxc));

  always #2 clk = ~clk;

  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================================
  // wishbone classic cycles
  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [7:0] q);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, m, e, input string what);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, {24'h000000, q & m}, {24'h000000, e});
  endtask

  task automatic wait_for(input bit on_tick, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (on_tick ? tick !== 1'b1 : txv !== 1'b0);
  endtask

  function automatic logic [8:0] char_of(input int k);
    return {k[0], 8'(8'h30 + 17 * k)};
  endfunction

  // ==========================================================
  // test sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ADR_RX_DATA, 8'hFF, 8'h00, "rx data reset");
    rd(ADR_TX_DATA, 8'hFF, 8'h00, "tx data reset");
    rd(ADR_BAUD_LO, 8'hFF, 8'h00, "baud low reset");
    rd(ADR_BAUD_HI, 8'hFF, 8'h00, "baud high reset");
    rd(ADR_TX_CTRL, 8'h02, 8'h02, "tx free reset");
    rd(8'h1C, 8'hFF, 8'h00, "unmapped read");
    wr(ADR_RX_DATA, 8'hA5);
    rd(ADR_RX_DATA, 8'hFF, 8'h00, "rx data read only");
    $display("test reset done");
    // fill the fifo and buffer until refused, then drain in order
    for (int k = 0; k < 9; k++) i_spb_partner.send(char_of(k));
    repeat (2) @(posedge clk);
    chk("rx ready when full", {31'h0, rxr}, 32'h0);
    for (int k = 0; k < 9; k++) begin
      rd(ADR_RX_CTRL, 8'h03, {6'h00, 1'b1, k[0]}, "rx status");
      rd(ADR_RX_DATA, 8'hFF, 8'(char_of(k)), "rx data");
    end
    rd(ADR_RX_CTRL, 8'h02, 8'h00, "rx empty");
    chk("rx ready drained", {31'h0, rxr}, 32'h1);
    $display("test receive done");
    // transmit with the shifter stalled, then released
    stall <= 1'b1;
    wr(ADR_TX_CTRL, 8'h01);
    wr(ADR_TX_DATA, 8'h3C);
    chk("tx held char", {22'h0, txv, txc}, 32'h0000033C);
    rd(ADR_TX_CTRL, 8'h03, 8'h01, "tx busy status");
    wr(ADR_TX_DATA, 8'h55);
    chk("tx refused write", {22'h0, txv, txc}, 32'h0000033C);
    stall <= 1'b0;
    wait_for(1'b0, c1);
    wr(ADR_TX_CTRL, 8'h00);
    wr(ADR_TX_DATA, 8'h5A);
    wait_for(1'b0, c1);
    chk("tx sent first", 32'(i_spb_partner.tx_got[0]), 32'h13C);
    chk("tx sent second", 32'(i_spb_partner.tx_got[1]), 32'h05A);
    rd(ADR_TX_DATA, 8'hFF, 8'h5A, "tx readback");
    $display("test transmit done");
    // every divider mode, restarted by each divider byte write
    for (int i = 0; i < 6; i++) begin
      wr(ADR_BAUD_CTRL, bc_tab[i]);
      wr(ADR_TX_CTRL, tx_tab[i]);
      wr(ADR_BAUD_HI, 8'h01);
      wr(ADR_BAUD_LO, 8'h02);
      wait_for(1'b1, c1);
      repeat (5) @(posedge clk);
      wr(ADR_BAUD_HI, 8'h01);
      wait_for(1'b1, c2);
      chk("restart phase", c2, c1);
      wait_for(1'b1, c3);
      gap_exp = p_tab[i] * (bc_tab[i][3] ? 259 : 3);
      chk("baud gap", c3, gap_exp);
    end
    rd(ADR_BAUD_LO, 8'hFF, 8'h02, "baud low readback");
    rd(ADR_BAUD_HI, 8'hFF, 8'h01, "baud high readback");
    $display("test baud done");
    stop_test();
  end
endmodule
